// File: verilog/mors_pkg.sv
// Package of constants and types for the move, OR, return and halt executor.
package mors_pkg;
  // Data path and address widths, and the interrupt event count.
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int PC_W = 8;
  localparam int INSTR_W = 12;
  localparam int BADDR_W = 6;
  localparam int NEV = 3;
  // Instruction field positions.
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 5;
  localparam int FADDR_HI = 4;
  localparam int LIT_HI = 7;
  // Major opcodes in the top four bits of an instruction word.
  localparam logic [3:0] OPC_MISC = 4'h0;
  localparam logic [3:0] OPC_OR = 4'h1;
  localparam logic [3:0] OPC_COPY = 4'h2;
  localparam logic [3:0] OPC_STORE = 4'h3;
  localparam logic [3:0] OPC_RETLIT = 4'h8;
  localparam logic [3:0] OPC_LDLIT = 4'hc;
  // Low byte of the miscellaneous group selects the operation.
  localparam logic [7:0] MISC_IDLE = 8'h00;
  localparam logic [7:0] MISC_CFG = 8'h02;
  localparam logic [7:0] MISC_HALT = 8'h03;
  // Register port byte map; file registers sit at 00 to 1f.
  localparam logic [5:0] A_ACC = 6'h20;
  localparam logic [5:0] A_FLAGS = 6'h21;
  localparam logic [5:0] A_CFG = 6'h22;
  localparam logic [5:0] A_PC = 6'h23;
  localparam logic [5:0] A_IST = 6'h24;
  localparam logic [5:0] A_ICLR = 6'h25;
  localparam logic [5:0] A_IEN = 6'h26;
  // Bit positions inside the flag register.
  localparam int FL_NULL = 0;
  localparam int FL_PWRDN = 1;
  localparam int FL_TMO = 2;
  localparam int FL_WAKE = 3;
  // Bit positions of the interrupt events.
  localparam int EV_HALT = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_NULL = 2;
  // Reset values and the program counter step.
  localparam logic [7:0] FLAGS_RST = 8'h06;
  localparam logic [7:0] CFG_RST = 8'hff;
  localparam logic [7:0] PC_RST = 8'h00;
  localparam logic [7:0] PC_STEP = 8'h01;
  // Sequencer states.
  typedef enum logic [1:0] {MORS_RUN, MORS_RET2, MORS_HALT} mors_state_t;
endpackage

// File: verilog/mors_bank_if.sv
// Interface between the executor core and its file register bank.
`timescale 1ns/10ps
interface mors_bank_if;
  import mors_pkg::*;
  logic [FADDR_W-1:0] ex_addr;  // Operand address of the executing word.
  logic [DATA_W-1:0] ex_rdata;  // Operand value, combinational.
  logic [FADDR_W-1:0] bus_addr; // Register port read address.
  logic [DATA_W-1:0] bus_rdata; // Register port read value.
  logic we;                     // Write enable for the single write port.
  logic [FADDR_W-1:0] waddr;    // Write address.
  logic [DATA_W-1:0] wdata;     // Write data.
  modport core (output ex_addr, bus_addr, we, waddr, wdata,
                input ex_rdata, bus_rdata);
  modport bank (input ex_addr, bus_addr, we, waddr, wdata,
                output ex_rdata, bus_rdata);
endinterface

// File: verilog/mors_file_bank.sv
// Thirty-two byte file register bank with two read ports and one write port.
`timescale 1ns/10ps
module mors_file_bank
  import mors_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  mors_bank_if.bank bank
);
  // Storage for the whole file space.
  logic [DATA_W-1:0] mem_r [2**FADDR_W];

  // Reads are combinational so an operand is ready in its own cycle.
  assign bank.ex_rdata = mem_r[bank.ex_addr];
  assign bank.bus_rdata = mem_r[bank.bus_addr];

  // Reset clears the bank so simulations start from known contents.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 2**FADDR_W; i++)
      begin
        mem_r[i] <= '0;
      end
    end
    else if (bank.we)
    begin
      mem_r[bank.waddr] <= bank.wdata;
    end
  end
endmodule

// File: verilog/mors_core.sv
// Executor for OR, moves, idle, config load, literal return and halt.
// Notes on behaviour
// - OR accumulator with file, set null flag
// - Destination bit zero: accumulator; one: file register
// - Copy file to destination, set null flag
// - Store accumulator to file, flags untouched
// - Load literal into accumulator, flags untouched
// - Copy accumulator into prescaler config register
// - Return: literal to accumulator, stack top to PC
// - Return takes two instruction cycles
// - Halt clears watchdog counter and its prescaler
// - Halt sets timeout flag, clears powerdown flag
// - Halt stops oscillator; no further instructions until a wake edge
`timescale 1ns/10ps
module mors_core
  import mors_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [mors_pkg::INSTR_W-1:0] instr_i,
  input wire logic [mors_pkg::PC_W-1:0] stack_top_i,
  input wire logic wake_i,
  input wire logic [mors_pkg::BADDR_W-1:0] addr_i,
  input wire logic [mors_pkg::DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [mors_pkg::DATA_W-1:0] rdata_o,
  output logic instr_ready_o,
  output logic [mors_pkg::PC_W-1:0] pc_o,
  output logic stack_pop_o,
  output logic wdt_clear_o,
  output logic wdt_pre_clear_o,
  output logic halted_o,
  output logic osc_en_o,
  output logic [mors_pkg::DATA_W-1:0] prescaler_config_o,
  output logic irq_o
);
  import mors_pkg::*;

  // True when a register port address lands in the file space.
  function automatic logic is_file_addr(input logic [BADDR_W-1:0] a);
    is_file_addr = (a[BADDR_W-1] == 1'b0);
  endfunction

  mors_bank_if bank_if ();

  // Architectural state.
  mors_state_t state_r;                   // Sequencer state.
  mors_state_t state_nxt;                 // Its next value.
  logic [DATA_W-1:0] acc_reg_r;           // The accumulator.
  logic [DATA_W-1:0] acc_reg_nxt;
  logic [DATA_W-1:0] flags_r;             // Status flags.
  logic [DATA_W-1:0] flags_nxt;
  logic [DATA_W-1:0] cfg_r;               // Prescaler configuration.
  logic [PC_W-1:0] pc_r;                  // Program counter.
  logic [PC_W-1:0] pc_nxt;
  logic [NEV-1:0] ist_r;                  // Sticky interrupt status.
  logic [NEV-1:0] ist_nxt;
  logic [NEV-1:0] ien_r;                  // Interrupt enables.
  logic [DATA_W-1:0] rdata_r;             // Registered read data.
  logic ready_r;                          // Instruction accept flag.
  logic pop_r;                            // Stack pop pulse.
  logic wdt_clr_r;                        // Watchdog clear pulse.
  logic irq_r;                            // Interrupt line.
  logic wake_s1_r;                        // Wake synchroniser, first.
  logic wake_s2_r;                        // Wake synchroniser, second.
  logic wake_s3_r;                        // Delayed copy for the edge.
  logic halt_r; // Registered halt level.
  logic osc_en_r; // Registered oscillator enable level.

  // Instruction field extraction.
  // Ready, not the state, gates acceptance, so a word offered in the
  // first cycle after reset is refused just as the ready pin says.
  wire take = instr_valid_i & ready_r;
  wire [3:0] opc = instr_i[OPC_HI:OPC_LO];
  wire dest_file = instr_i[DEST_BIT];
  wire [FADDR_W-1:0] faddr = instr_i[FADDR_HI:0];
  wire [DATA_W-1:0] lit = instr_i[LIT_HI:0];

  // One decoded strobe per operation but idle, qualified by acceptance.
  wire is_or = take & (opc == OPC_OR);
  wire is_copy = take & (opc == OPC_COPY);
  wire is_store = take & (opc == OPC_STORE);
  wire is_ldlit = take & (opc == OPC_LDLIT);
  wire is_retlit = take & (opc == OPC_RETLIT);
  wire is_misc = take & (opc == OPC_MISC);
  wire is_cfg = is_misc & (lit == MISC_CFG);
  wire is_halt = is_misc & (lit == MISC_HALT);

  // Result path shared by the OR and the copy.
  wire [DATA_W-1:0] operand = bank_if.ex_rdata;
  wire [DATA_W-1:0] res = is_or ? (acc_reg_r | operand) : operand;
  wire res_upd = is_or | is_copy;
  wire res_null = (res == '0);
  wire res_to_acc = res_upd & ~dest_file;
  wire res_to_file = res_upd & dest_file;

  // Register port decode.
  wire bus_file_wr = we_i & is_file_addr(addr_i);
  wire acc_wr = we_i & (addr_i == A_ACC);
  wire flags_wr = we_i & (addr_i == A_FLAGS);
  wire cfg_wr = we_i & (addr_i == A_CFG);
  wire iclr_wr = we_i & (addr_i == A_ICLR);
  wire ien_wr = we_i & (addr_i == A_IEN);

  // Wake edge is seen only from the second and third stages.
  wire wake_rise = wake_s2_r & ~wake_s3_r;
  wire wake_evt = (state_r == MORS_HALT) & wake_rise;

  // File bank hook-up; an executing write owns the port over software.
  wire ex_file_wr = res_to_file | is_store;
  assign bank_if.ex_addr = faddr;
  assign bank_if.bus_addr = addr_i[FADDR_W-1:0];
  assign bank_if.we = ex_file_wr | bus_file_wr;
  assign bank_if.waddr = ex_file_wr ? faddr : addr_i[FADDR_W-1:0];
  assign bank_if.wdata = is_store ? acc_reg_r :
                         res_to_file ? res : wdata_i;

  mors_file_bank u_bank (
    .clk_i (clk_i),
    .rstn_i (rstn_i),
    .bank (bank_if.bank)
  );

  // Accumulator source: executing writes win over a software write.
  assign acc_reg_nxt = res_to_acc ? res :
                       (is_ldlit | is_retlit) ? lit :
                       acc_wr ? wdata_i : acc_reg_r;

  // Flag updates; only OR and copy touch the null flag, and only halt
  // touches timeout and powerdown. Store, literal, return, config and
  // idle leave every flag as it was.
  always_comb
  begin
    flags_nxt = flags_r;
    if (flags_wr)
    begin
      // Software may write both the null flag and the wake flag.
      flags_nxt[FL_NULL] = wdata_i[FL_NULL];
      flags_nxt[FL_WAKE] = wdata_i[FL_WAKE];
    end
    if (res_upd)
    begin
      flags_nxt[FL_NULL] = res_null;
    end
    if (is_halt)
    begin
      flags_nxt[FL_TMO] = 1'b1;
      flags_nxt[FL_PWRDN] = 1'b0;
    end
    if (wake_evt)
    begin
      // A wake beats a same-cycle software clear of the wake flag.
      flags_nxt[FL_WAKE] = 1'b1;
    end
  end

  // Program counter: return jumps, everything else steps by one.
  assign pc_nxt = is_retlit ? stack_top_i :
                  take ? pc_r + PC_STEP : pc_r;

  // Sequencer. Return holds one extra cycle while the fetch refills;
  // halt parks until a synchronised wake edge arrives.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MORS_RUN:
      begin
        if (is_retlit)
        begin
          state_nxt = MORS_RET2;
        end
        else if (is_halt)
        begin
          state_nxt = MORS_HALT;
        end
      end
      MORS_RET2:
      begin
        state_nxt = MORS_RUN;
      end
      MORS_HALT:
      begin
        if (wake_rise)
        begin
          state_nxt = MORS_RUN;
        end
      end
      default:
      begin
        state_nxt = MORS_RUN;
      end
    endcase
  end

  // Halt is decoded once from the next state for both level pins.
  wire halt_nxt = (state_nxt == MORS_HALT);

  // Halt and clock-enable levels, registered from the next state so both
  // pins come straight off flops and show no decode glitch.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      halt_r <= 1'b0;
      osc_en_r <= 1'b1;
    end
    else
    begin
      halt_r <= halt_nxt;
      osc_en_r <= ~halt_nxt;
    end
  end

  // Interrupt events, one sticky bit each; a set beats a clear.
  wire [NEV-1:0] ev;
  assign ev[EV_HALT] = is_halt;
  assign ev[EV_WAKE] = wake_evt;
  assign ev[EV_NULL] = res_upd & res_null;

  genvar gi;
  generate
    for (gi = 0; gi < NEV; gi++)
    begin : g_ist
      assign ist_nxt[gi] = ev[gi] | (ist_r[gi] & ~(iclr_wr & wdata_i[gi]));
    end
  endgenerate

  // Read mux; write-only and unmapped addresses read as zero.
  wire [DATA_W-1:0] rd_val =
    is_file_addr(addr_i) ? bank_if.bus_rdata :
    (addr_i == A_ACC) ? acc_reg_r :
    (addr_i == A_FLAGS) ? flags_r :
    (addr_i == A_CFG) ? cfg_r :
    (addr_i == A_PC) ? pc_r :
    (addr_i == A_IST) ? {{(DATA_W-NEV){1'b0}}, ist_r} :
    (addr_i == A_IEN) ? {{(DATA_W-NEV){1'b0}}, ien_r} : '0;

  // Wake pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      wake_s3_r <= 1'b0;
    end
    else
    begin
      wake_s1_r <= wake_i;
      wake_s2_r <= wake_s1_r;
      wake_s3_r <= wake_s2_r;
    end
  end

  // Core state registers.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= MORS_RUN;
      acc_reg_r <= '0;
      flags_r <= FLAGS_RST;
      pc_r <= PC_RST;
    end
    else
    begin
      state_r <= state_nxt;
      acc_reg_r <= acc_reg_nxt;
      flags_r <= flags_nxt;
      pc_r <= pc_nxt;
    end
  end

  // Configuration register: the config instruction wins over software.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_r <= CFG_RST;
    end
    else if (is_cfg)
    begin
      cfg_r <= acc_reg_r;
    end
    else if (cfg_wr)
    begin
      cfg_r <= wdata_i;
    end
  end

  // Interrupt registers and the level output.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ist_r <= '0;
      ien_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      ist_r <= ist_nxt;
      if (ien_wr)
      begin
        ien_r <= wdata_i[NEV-1:0];
      end
      irq_r <= |(ist_nxt & (ien_wr ? wdata_i[NEV-1:0] : ien_r));
    end
  end

  // Pulses and port-side registers. Idle reaches none of them except
  // through the program counter step.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_r <= '0;
      ready_r <= 1'b0;
      pop_r <= 1'b0;
      wdt_clr_r <= 1'b0;
    end
    else
    begin
      rdata_r <= re_i ? rd_val : '0;
      ready_r <= (state_nxt == MORS_RUN);
      pop_r <= is_retlit;
      wdt_clr_r <= is_halt;
    end
  end

  // Output drive, each straight from a flip-flop.
  assign rdata_o = rdata_r;
  assign instr_ready_o = ready_r;
  assign pc_o = pc_r;
  assign stack_pop_o = pop_r;
  assign wdt_clear_o = wdt_clr_r;
  assign wdt_pre_clear_o = wdt_clr_r;
  assign halted_o = halt_r;
  assign osc_en_o = osc_en_r;
  assign prescaler_config_o = cfg_r;
  assign irq_o = irq_r;
endmodule

// File: verif/mors_core_checker.sv
// Port-level checker for the move, OR, return and halt executor.
`timescale 1ns/10ps
module mors_core_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [mors_pkg::INSTR_W-1:0] instr_i,
  input wire logic [mors_pkg::PC_W-1:0] stack_top_i,
  input wire logic wake_i,
  input wire logic [mors_pkg::BADDR_W-1:0] addr_i,
  input wire logic [mors_pkg::DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [mors_pkg::DATA_W-1:0] rdata_o,
  input wire logic instr_ready_o,
  input wire logic [mors_pkg::PC_W-1:0] pc_o,
  input wire logic stack_pop_o,
  input wire logic wdt_clear_o,
  input wire logic wdt_pre_clear_o,
  input wire logic halted_o,
  input wire logic osc_en_o,
  input wire logic [mors_pkg::DATA_W-1:0] prescaler_config_o,
  input wire logic irq_o
);
  import mors_pkg::*;
  logic [3:0] opc;   // Opcode field of the offered word.
  logic take;        // The core takes the offered word at this edge.
  logic take_ret;    // A literal return is taken.
  logic take_halt;   // A halt is taken.
  logic take_cfg;    // A config load is taken.
  logic take_idle;   // An idle word is taken.
  assign opc = instr_i[OPC_HI:OPC_LO];
  assign take = instr_valid_i && instr_ready_o;
  assign take_ret = take && (opc == OPC_RETLIT);
  assign take_halt = take && (opc == OPC_MISC) && (instr_i[7:0] == MISC_HALT);
  assign take_cfg = take && (opc == OPC_MISC) && (instr_i[7:0] == MISC_CFG);
  assign take_idle = take && (opc == OPC_MISC) && (instr_i[7:0] == MISC_IDLE);

  // Checks below are all on the one clock, idle while reset is low.
  a_halt_wdt_clear: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take_halt |=> wdt_clear_o && wdt_pre_clear_o)
    else $error("watchdog not cleared");
  a_wdt_clear_cause: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    wdt_clear_o |-> $past(take_halt) && wdt_pre_clear_o)
    else $error("stray clear");
  a_halt_stops_core: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take_halt |=> halted_o && !osc_en_o && !instr_ready_o)
    else $error("no halt");
  // Four quiet samples of the wake pin keep any synchronised edge out.
  a_halt_stays_put: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    halted_o && !wake_i && !$past(wake_i) && !$past(wake_i, 2)
    && !$past(wake_i, 3) |=> halted_o && $stable(pc_o))
    else $error("halt left or pc moved");
  a_ret_two_cycles: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take_ret |=> stack_pop_o && !instr_ready_o ##1 instr_ready_o)
    else $error("return length wrong");
  a_ret_loads_pc: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take_ret |=> pc_o == $past(stack_top_i))
    else $error("return pc wrong");
  a_pop_cause: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    stack_pop_o |-> $past(take_ret))
    else $error("stray stack pop");
  a_pc_step_one: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && (opc != OPC_RETLIT) |=> pc_o == $past(pc_o) + PC_STEP)
    else $error("pc did not step by one");
  a_cfg_change_cause: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !$stable(prescaler_config_o)
    |-> $past(take_cfg || (we_i && addr_i == A_CFG)))
    else $error("config changed without cause");
  a_idle_quiet: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take_idle && !we_i |=> $stable(prescaler_config_o) && !stack_pop_o
    && !wdt_clear_o && !halted_o) else $error("idle had a side effect");
endmodule

bind mors_core mors_core_checker u_mors_core_checker (
  .clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .stack_top_i(stack_top_i), .wake_i(wake_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
  .rdata_o(rdata_o), .instr_ready_o(instr_ready_o), .pc_o(pc_o),
  .stack_pop_o(stack_pop_o), .wdt_clear_o(wdt_clear_o),
  .wdt_pre_clear_o(wdt_pre_clear_o), .halted_o(halted_o),
  .osc_en_o(osc_en_o), .prescaler_config_o(prescaler_config_o),
  .irq_o(irq_o)
);

// File: verif/test_mors_core.sv
// Self-checking bench for the move, OR, return and halt executor.
`timescale 1ns/10ps
module test_mors_core;
  import mors_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = '0;
  logic [PC_W-1:0] stack_top_i = 8'h40; // Return address offered.
  logic wake_i = 1'b0;
  logic [BADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic instr_ready_o;
  logic [PC_W-1:0] pc_o;
  logic stack_pop_o;
  logic wdt_clear_o;
  logic wdt_pre_clear_o;
  logic halted_o;
  logic osc_en_o;
  logic [DATA_W-1:0] prescaler_config_o;
  logic irq_o;
  int bad_count = 0;
  int cmp_count = 0;
  logic [PC_W-1:0] pc_e = PC_RST; // Expected program counter.

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  mors_core u_mors_core (
    .clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .stack_top_i(stack_top_i), .wake_i(wake_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .instr_ready_o(instr_ready_o), .pc_o(pc_o),
    .stack_pop_o(stack_pop_o), .wdt_clear_o(wdt_clear_o),
    .wdt_pre_clear_o(wdt_pre_clear_o), .halted_o(halted_o),
    .osc_en_o(osc_en_o), .prescaler_config_o(prescaler_config_o),
    .irq_o(irq_o)
  );

  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One-cycle register write; returns just after the taking edge.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    begin
      @(posedge clk_i);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      we_i <= 1'b0;
      #1;
    end
  endtask

  // One-cycle register read; the data stand only in the following cycle.
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    begin
      @(posedge clk_i);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1;
      chk(rdata_o, e);
    end
  endtask

  // Offers one word and holds it until an edge with ready high takes it.
  task automatic ex(input logic [INSTR_W-1:0] w);
    int n;
    logic ok;
    begin
      n = 0;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= w;
      do
      begin
        #1;
        ok = (instr_ready_o === 1'b1);
        @(posedge clk_i);
        n++;
      end while (!ok && n < 20);
      instr_valid_i <= 1'b0;
      #1;
      // A word never taken counts as a fault.
      if (!ok)
        chk(8'h00, 8'h01);
      pc_e = (w[11:8] == OPC_RETLIT) ? stack_top_i : pc_e + PC_STEP;
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic close_out;
    begin
      if (bad_count == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // Main sequence of instruction and register port calls.
  initial
  begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(A_FLAGS, FLAGS_RST);
    rd(A_CFG, CFG_RST);
    wr(6'h03, 8'h50);
    wr(6'h04, 8'h81);
    ex(12'hc0a);
    rd(A_ACC, 8'h0a);
    ex(12'h103);
    rd(A_ACC, 8'h5a);
    rd(A_FLAGS, 8'h06);
    ex(12'h124);
    rd(6'h04, 8'hdb);
    rd(A_ACC, 8'h5a);
    ex(12'hc00);
    ex(12'h105);
    rd(A_FLAGS, 8'h07);
    wr(A_IEN, 8'h04);
    rd(A_IST, 8'h04);
    chk({7'h00, irq_o}, 8'h01);
    wr(A_ICLR, 8'h04);
    rd(A_IST, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    // Copy back onto itself is the nonzero test; a zero copy to acc follows.
    ex(12'hc77);
    ex(12'h223);
    rd(A_FLAGS, 8'h06);
    rd(A_ACC, 8'h77);
    rd(6'h03, 8'h50);
    ex(12'h205);
    rd(A_ACC, 8'h00);
    rd(A_FLAGS, 8'h07);
    ex(12'hc3c);
    ex(12'h307);
    rd(6'h07, 8'h3c);
    rd(A_FLAGS, 8'h07);
    ex(12'h000);
    rd(A_PC, pc_e);
    rd(A_ACC, 8'h3c);
    // Both ends of the literal range.
    ex(12'hc00);
    rd(A_ACC, 8'h00);
    ex(12'hcff);
    rd(A_ACC, 8'hff);
    rd(A_FLAGS, 8'h07);
    ex(12'hca5);
    ex(12'h002);
    rd(A_CFG, 8'ha5);
    chk(prescaler_config_o, 8'ha5);
    rd(A_FLAGS, 8'h07);
    ex(12'h8e4);
    chk({6'h00, stack_pop_o, instr_ready_o}, 8'h02);
    rd(A_ACC, 8'he4);
    rd(A_PC, 8'h40);
    rd(A_FLAGS, 8'h07);
    // Halt with halt and wake events enabled.
    wr(A_ICLR, 8'h07);
    wr(A_IEN, 8'h03);
    ex(12'h003);
    chk({6'h00, wdt_clear_o, wdt_pre_clear_o}, 8'h03);
    chk({6'h00, halted_o, osc_en_o}, 8'h02);
    // A word offered while halted must be ignored.
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= 12'hc11;
    repeat (6) @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    chk({wdt_clear_o, halted_o, irq_o, 5'h00}, 8'h60);
    chk(pc_o, pc_e);
    @(posedge clk_i);
    wake_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    chk({6'h00, halted_o, instr_ready_o}, 8'h01);
    rd(A_FLAGS, 8'h0d);
    rd(A_ACC, 8'he4);
    rd(A_IST, 8'h03);
    rd(6'h3f, 8'h00);
    wr(A_PC, 8'hff);
    rd(A_PC, pc_e);
    close_out();
  end

  // Cuts a hang short well beyond the 140 or so cycles needed.
  initial
  begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    close_out();
  end
endmodule
